// file: hw/uia_arbiter.sv
// module: uart interrupt arbiter with wishbone register slave
`timescale 1ns/1ns
`default_nettype none
module uia_arbiter (
    // clock and reset
    input  wire  logic                   mclk_i,
    input  wire  logic                   rst_n_i,
    // wishbone slave
    input  wire  uia_pkg::uia_wb_req_s   wb_req_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    // interrupt pins
    input  wire  logic                   intr_ack_strobe_n_i,
    output logic                         intr_request_n_o,
    output logic [7:0]                   vector_o,
    output logic [uia_pkg::BIDW-1:0]     current_winner_capture_o,
    // fifo sources
    input  wire  logic [8:0]             rx_count_i,
    input  wire  logic                   rx_error_i,
    input  wire  logic [8:0]             tx_empty_i,
    // event sources, one-cycle pulses, then the channel bits of the cos and ct bids
    input  wire  logic                   wdog_evt_i,
    input  wire  logic                   brk_evt_i,
    input  wire  logic                   lpbk_evt_i,
    input  wire  logic                   cos_evt_i,
    input  wire  logic                   xon_evt_i,
    input  wire  logic                   ct_evt_i,
    input  wire  logic                   addr_evt_i,
    input  wire  logic                   cos_port_i,
    input  wire  logic                   ct_unit_i
);
    localparam uia_pkg::uia_state_s RST = '{irq_n: 1'b1, ack_s1: 1'b1, ack_s2: 1'b1, ack_s3: 1'b1,
                                            vec_base: uia_pkg::VEC_RESET, vec: uia_pkg::VEC_RESET,
                                            default: '0};

    uia_pkg::uia_state_s s_r;
    uia_pkg::uia_state_s s_nxt;
    uia_pkg::uia_bids_t  bids;
    uia_pkg::uia_bids_t  elig;
    logic [uia_pkg::NSRC-1:0] act;
    logic [uia_pkg::NSRC-1:0] ev_set;
    logic [uia_pkg::BIDW-1:0] best;
    logic [7:0] rx_cnt8;
    logic [7:0] tx_cnt8;
    logic       rx_start;
    logic       tx_start;
    logic       wr;
    logic       rd;
    logic       ack_edge;
    logic       cmd_upd;
    logic [31:0] mrg_mask;
    logic [31:0] mrg_clr;
    logic [31:0] mrg_thr;

    // ---------------------------------------------------------------
    // fifo level qualification
    // ---------------------------------------------------------------
    function automatic logic lvl_met(input logic [1:0] sel, input logic [8:0] cnt);
        case (sel)
            2'h0:    lvl_met = (cnt != 9'h000);
            2'h1:    lvl_met = (cnt >= uia_pkg::LVL_HALF);
            2'h2:    lvl_met = (cnt >= uia_pkg::LVL_3Q);
            default: lvl_met = (cnt >= uia_pkg::LVL_FULL);
        endcase
    endfunction : lvl_met

    // byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                m[8*b +: 8] = nw[8*b +: 8];
            end
        end
        merge = m;
    endfunction : merge

    // level start and 8-bit saturated counts
    assign rx_start = lvl_met(s_r.rx_lvl, rx_count_i);
    assign tx_start = lvl_met(s_r.tx_lvl, tx_empty_i);
    assign rx_cnt8  = rx_count_i[8] ? 8'hff : rx_count_i[7:0];
    assign tx_cnt8  = tx_empty_i[8] ? 8'hff : tx_empty_i[7:0];

    // ---------------------------------------------------------------
    // bid assembly
    // ---------------------------------------------------------------
    always_comb begin
        bids                     = '0;
        bids[uia_pkg::SRC_RX_OK] = {rx_cnt8, uia_pkg::TY_RX_OK, uia_pkg::CHAN};
        bids[uia_pkg::SRC_RX_ER] = {rx_cnt8, uia_pkg::TY_RX_ER, uia_pkg::CHAN};
        bids[uia_pkg::SRC_WDOG]  = {rx_cnt8, uia_pkg::TY_WDOG, uia_pkg::CHAN};
        bids[uia_pkg::SRC_TX]    = {tx_cnt8, uia_pkg::TY_TX, uia_pkg::CHAN};
        bids[uia_pkg::SRC_BRK]   = {s_r.prg[0], uia_pkg::TY_BRK, uia_pkg::CHAN};
        bids[uia_pkg::SRC_LPBK]  = {s_r.prg[1], uia_pkg::TY_LPBK, uia_pkg::CHAN};
        bids[uia_pkg::SRC_COS]   = {s_r.prg[2], uia_pkg::TY_COS, cos_port_i};
        bids[uia_pkg::SRC_XON]   = {s_r.prg[3], uia_pkg::TY_XON, uia_pkg::CHAN};
        bids[uia_pkg::SRC_CT]    = {s_r.prg[4], uia_pkg::TY_CT, ct_unit_i};
        bids[uia_pkg::SRC_ADDR]  = {s_r.prg[5], uia_pkg::TY_ADDR, uia_pkg::CHAN};
    end

    // active conditions: fifo levels and sticky events
    always_comb begin
        act                     = s_r.ev;
        act[uia_pkg::SRC_RX_OK] = rx_start & ~rx_error_i;
        act[uia_pkg::SRC_RX_ER] = rx_error_i & (rx_count_i != 9'h000);
        act[uia_pkg::SRC_TX]    = tx_start;
    end

    // event pulses into sticky positions
    always_comb begin
        ev_set                    = '0;
        ev_set[uia_pkg::SRC_WDOG] = wdog_evt_i;
        ev_set[uia_pkg::SRC_BRK]  = brk_evt_i;
        ev_set[uia_pkg::SRC_LPBK] = lpbk_evt_i;
        ev_set[uia_pkg::SRC_COS]  = cos_evt_i;
        ev_set[uia_pkg::SRC_XON]  = xon_evt_i;
        ev_set[uia_pkg::SRC_CT]   = ct_evt_i;
        ev_set[uia_pkg::SRC_ADDR] = addr_evt_i;
    end

    // eligibility: enabled, active and above threshold, else zero
    genvar g;
    generate
        for (g = 0; g < uia_pkg::NSRC; g++) begin : g_elig
            assign elig[g] = (s_r.mask[g] && act[g] && (bids[g][uia_pkg::BIDW-1:1] > s_r.thr))
                             ? bids[g] : '0;
        end
    endgenerate

    // highest bid, evaluated on every second clock
    uia_bid_max u_max (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .eval_i  (s_r.phase),
        .bids_i  (elig),
        .best_o  (best)
    );

    // ---------------------------------------------------------------
    // bus decode and strobes
    // ---------------------------------------------------------------
    assign wr       = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~s_r.ack;
    assign rd       = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~s_r.ack;
    assign ack_edge = s_r.ack_s3 & ~s_r.ack_s2;
    assign cmd_upd  = wr && (wb_req_i.adr == uia_pkg::ADR_CMD) && wb_req_i.sel[0]
                      && (wb_req_i.dat[7:0] == uia_pkg::CMD_UPDATE);
    // byte-merged write words, cut to each field width where used
    assign mrg_mask = merge(32'(s_r.mask), wb_req_i.dat, wb_req_i.sel);
    assign mrg_clr  = merge(32'h0, wb_req_i.dat, wb_req_i.sel);
    assign mrg_thr  = merge(32'(s_r.thr), wb_req_i.dat, wb_req_i.sel);

    // next state
    always_comb begin
        s_nxt        = s_r;
        s_nxt.ack    = wb_req_i.cyc & wb_req_i.stb & ~s_r.ack;
        s_nxt.phase  = ~s_r.phase;
        s_nxt.ack_s1 = intr_ack_strobe_n_i;
        s_nxt.ack_s2 = s_r.ack_s1;
        s_nxt.ack_s3 = s_r.ack_s2;
        s_nxt.irq_n  = (best == '0);
        s_nxt.ev     = s_r.ev | ev_set;
        // register writes
        if (wr) begin
            case (wb_req_i.adr)
                uia_pkg::ADR_MASK: begin
                    s_nxt.mask = mrg_mask[uia_pkg::NSRC-1:0];
                end
                uia_pkg::ADR_STAT: begin
                    // write one clears, a new event wins
                    s_nxt.ev = (s_r.ev & ~mrg_clr[uia_pkg::NSRC-1:0]) | ev_set;
                end
                uia_pkg::ADR_THR: begin
                    s_nxt.thr = mrg_thr[uia_pkg::THRW-1:0];
                end
                uia_pkg::ADR_MODE1: begin
                    if (wb_req_i.sel[0]) begin
                        s_nxt.mode1_msk = wb_req_i.dat[uia_pkg::MODE1_MSK_BIT];
                    end
                end
                uia_pkg::ADR_LVL: begin
                    if (wb_req_i.sel[0]) begin
                        s_nxt.rx_lvl = wb_req_i.dat[1:0];
                        s_nxt.tx_lvl = wb_req_i.dat[3:2];
                    end
                end
                uia_pkg::ADR_VEC: begin
                    if (wb_req_i.sel[0]) begin
                        s_nxt.vec_base = wb_req_i.dat[7:0];
                    end
                    if (wb_req_i.sel[1]) begin
                        s_nxt.vec_mod = wb_req_i.dat[uia_pkg::VEC_MOD_BIT];
                    end
                end
                default: begin
                    if ((wb_req_i.adr >= uia_pkg::ADR_PRG0) && (wb_req_i.adr <= uia_pkg::ADR_PRGN)
                        && (wb_req_i.adr[1:0] == 2'h0) && wb_req_i.sel[0]) begin
                        s_nxt.prg[3'(wb_req_i.adr[7:2] - uia_pkg::ADR_PRG0[7:2])] = wb_req_i.dat[6:0];
                    end
                end
            endcase
        end
        // capture on acknowledge edge or update command
        if (ack_edge || cmd_upd) begin
            s_nxt.cap = best;
            s_nxt.vec = s_r.vec_mod ? {s_r.vec_base[7:5], best[4:1], best[0]} : s_r.vec_base;
        end
        // read data, zero for unmapped offsets
        s_nxt.dat = '0;
        if (rd) begin
            case (wb_req_i.adr)
                uia_pkg::ADR_MASK:  s_nxt.dat = 32'(s_r.mask);
                uia_pkg::ADR_STAT:  s_nxt.dat = 32'(s_r.mode1_msk ? (act & s_r.mask) : act);
                uia_pkg::ADR_THR:   s_nxt.dat = 32'(s_r.thr);
                uia_pkg::ADR_MODE1: s_nxt.dat = 32'(s_r.mode1_msk) << uia_pkg::MODE1_MSK_BIT;
                uia_pkg::ADR_LVL:   s_nxt.dat = 32'({s_r.tx_lvl, s_r.rx_lvl});
                uia_pkg::ADR_CAP:   s_nxt.dat = 32'(s_r.cap);
                uia_pkg::ADR_VEC:   s_nxt.dat = 32'({s_r.vec_mod, s_r.vec_base});
                default: begin
                    if ((wb_req_i.adr >= uia_pkg::ADR_PRG0) && (wb_req_i.adr <= uia_pkg::ADR_PRGN)
                        && (wb_req_i.adr[1:0] == 2'h0)) begin
                        s_nxt.dat = 32'(s_r.prg[3'(wb_req_i.adr[7:2] - uia_pkg::ADR_PRG0[7:2])]);
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_r <= RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state
    assign wb_dat_o                 = s_r.dat;
    assign wb_ack_o                 = s_r.ack;
    assign intr_request_n_o         = s_r.irq_n;
    assign vector_o                 = s_r.vec;
    assign current_winner_capture_o = s_r.cap;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_req_follows_win;
        @(posedge mclk_i) disable iff (!rst_n_i)
        intr_request_n_o == ($past(best) == '0);
    endproperty
    a_req_follows_win: assert property (p_req_follows_win) else $error("request not tied to winner");

    property p_mask_blocks;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (s_r.mask == '0) [*4] |-> (best == '0) && intr_request_n_o;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked source won");

    property p_ack_capture;
        @(posedge mclk_i) disable iff (!rst_n_i)
        ack_edge |=> (current_winner_capture_o == $past(best));
    endproperty
    a_ack_capture: assert property (p_ack_capture) else $error("acknowledge capture wrong");

    property p_cmd_capture;
        @(posedge mclk_i) disable iff (!rst_n_i)
        cmd_upd |=> (current_winner_capture_o == $past(best));
    endproperty
    a_cmd_capture: assert property (p_cmd_capture) else $error("update command capture wrong");

    property p_cap_holds;
        @(posedge mclk_i) disable iff (!rst_n_i)
        !(ack_edge || cmd_upd) |=> $stable(current_winner_capture_o);
    endproperty
    a_cap_holds: assert property (p_cap_holds) else $error("capture changed without cause");

    property p_thr_exceed;
        @(posedge mclk_i) disable iff (!rst_n_i)
        $changed(best) && (best != '0) |-> (best[uia_pkg::BIDW-1:1] > $past(s_r.thr));
    endproperty
    a_thr_exceed: assert property (p_thr_exceed) else $error("winner not above threshold");

    property p_eval_cadence;
        @(posedge mclk_i) disable iff (!rst_n_i)
        $changed(best) |-> $past(s_r.phase) ##1 !$changed(best);
    endproperty
    a_eval_cadence: assert property (p_eval_cadence) else $error("arbitration off cadence");

    property p_wb_ack_pulse;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_wb_ack_pulse: assert property (p_wb_ack_pulse) else $error("bus acknowledge not one cycle");

    property p_none_zero;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ack_edge && (best == '0)) |=> (current_winner_capture_o == '0) && intr_request_n_o;
    endproperty
    a_none_zero: assert property (p_none_zero) else $error("empty capture not zero");

endmodule : uia_arbiter
`default_nettype wire

// file: hw/uia_pkg.sv
// package: constants, register map and carrier types of the uart interrupt arbiter
package uia_pkg;

    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int unsigned NSRC   = 10;
    localparam int unsigned BIDW   = 12;
    localparam int unsigned THRW   = 11;
    localparam int unsigned NPRG   = 6;
    localparam int unsigned PRGW   = 7;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADR_MASK  = 8'h00;
    localparam logic [7:0] ADR_STAT  = 8'h04;
    localparam logic [7:0] ADR_THR   = 8'h08;
    localparam logic [7:0] ADR_MODE1 = 8'h0c;
    localparam logic [7:0] ADR_LVL   = 8'h10;
    localparam logic [7:0] ADR_CMD   = 8'h14;
    localparam logic [7:0] ADR_CAP   = 8'h18;
    localparam logic [7:0] ADR_VEC   = 8'h1c;
    localparam logic [7:0] ADR_PRG0  = 8'h20;
    localparam logic [7:0] ADR_PRGN  = 8'h34;

    // ---------------------------------------------------------------
    // fields and codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_UPDATE    = 8'h01;
    localparam int unsigned MODE1_MSK_BIT = 6;
    localparam int unsigned VEC_MOD_BIT   = 8;
    localparam logic       CHAN          = 1'b0;
    localparam logic [7:0] VEC_RESET     = 8'h0f;

    // source indices
    localparam int unsigned SRC_RX_OK = 0;
    localparam int unsigned SRC_RX_ER = 1;
    localparam int unsigned SRC_WDOG  = 2;
    localparam int unsigned SRC_TX    = 3;
    localparam int unsigned SRC_BRK   = 4;
    localparam int unsigned SRC_LPBK  = 5;
    localparam int unsigned SRC_COS   = 6;
    localparam int unsigned SRC_XON   = 7;
    localparam int unsigned SRC_CT    = 8;
    localparam int unsigned SRC_ADDR  = 9;
    localparam int unsigned PRG_BASE  = SRC_BRK;

    // type codes, fifo sources use bits 3:1, programmed ones bits 4:1
    localparam logic [2:0] TY_RX_OK = 3'h1;
    localparam logic [2:0] TY_RX_ER = 3'h5;
    localparam logic [2:0] TY_WDOG  = 3'h4;
    localparam logic [2:0] TY_TX    = 3'h2;
    localparam logic [3:0] TY_BRK   = 4'he;
    localparam logic [3:0] TY_LPBK  = 4'hf;
    localparam logic [3:0] TY_COS   = 4'h6;
    localparam logic [3:0] TY_XON   = 4'h7;
    localparam logic [3:0] TY_CT    = 4'h8;
    localparam logic [3:0] TY_ADDR  = 4'hb;

    // fifo start levels (256 deep)
    localparam logic [8:0] LVL_HALF = 9'h080;
    localparam logic [8:0] LVL_3Q   = 9'h0c0;
    localparam logic [8:0] LVL_FULL = 9'h100;

    // ---------------------------------------------------------------
    // carrier types
    // ---------------------------------------------------------------
    typedef logic [NSRC-1:0][BIDW-1:0] uia_bids_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } uia_wb_req_s;

    typedef struct packed {
        logic [BIDW-1:0] best;
    } uia_max_s;

    typedef struct packed {
        logic                      ack;
        logic [31:0]               dat;
        logic [NSRC-1:0]           mask;
        logic [NSRC-1:0]           ev;
        logic [THRW-1:0]           thr;
        logic                      mode1_msk;
        logic [1:0]                rx_lvl;
        logic [1:0]                tx_lvl;
        logic [NPRG-1:0][PRGW-1:0] prg;
        logic [7:0]                vec_base;
        logic                      vec_mod;
        logic [BIDW-1:0]           cap;
        logic [7:0]                vec;
        logic                      irq_n;
        logic                      ack_s1;
        logic                      ack_s2;
        logic                      ack_s3;
        logic                      phase;
    } uia_state_s;

endpackage : uia_pkg

// file: hw/uia_bid_max.sv
// module: registered highest-bid selector over all source bids
`timescale 1ns/1ns
`default_nettype none
module uia_bid_max (
    // clock and reset
    input  wire  logic             mclk_i,
    input  wire  logic             rst_n_i,
    // evaluation strobe and bids
    input  wire  logic             eval_i,
    input  wire  uia_pkg::uia_bids_t bids_i,
    // result
    output logic [uia_pkg::BIDW-1:0] best_o
);
    uia_pkg::uia_max_s s_r;
    uia_pkg::uia_max_s s_nxt;
    logic [uia_pkg::BIDW-1:0] chain [0:uia_pkg::NSRC];

    // ---------------------------------------------------------------
    // compare chain
    // ---------------------------------------------------------------
    assign chain[0] = '0;
    genvar g;
    generate
        for (g = 0; g < uia_pkg::NSRC; g++) begin : g_max
            assign chain[g+1] = (bids_i[g] > chain[g]) ? bids_i[g] : chain[g];
        end
    endgenerate

    // next state: new result only on an evaluation strobe
    always_comb begin
        s_nxt = s_r;
        if (eval_i) begin
            s_nxt.best = chain[uia_pkg::NSRC];
        end
    end

    // state register
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign best_o = s_r.best;

endmodule : uia_bid_max
`default_nettype wire

// file: tb/uia_host.sv
// host model: wishbone master and acknowledge strobe of the processor side
`timescale 1ns/1ns
`default_nettype none
module uia_host (
    // clock
    input  wire logic                 mclk_i,
    // wishbone master
    output var  uia_pkg::uia_wb_req_s wb_req_o,
    input  wire logic [31:0]          wb_dat_i,
    input  wire logic                 wb_ack_i,
    // acknowledge pin
    output logic                      ack_n_o
);
    // idle bus and released pin at time zero
    initial begin
        wb_req_o = '0;
        ack_n_o  = 1'b1;
    end
    // one classic cycle, held until ack is sampled high
    task automatic cyc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk_i);
        wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        @(posedge mclk_i);
        while (wb_ack_i !== 1'b1) @(posedge mclk_i);
        q = wb_dat_i;
        wb_req_o <= '0;
    endtask : cyc
    // register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        cyc(1'b1, a, d, q);
    endtask : wr
    // update command, then read back the capture
    task automatic poll(output logic [31:0] q);
        wr(uia_pkg::ADR_CMD, 32'(uia_pkg::CMD_UPDATE));
        cyc(1'b0, uia_pkg::ADR_CAP, '0, q);
    endtask : poll
    // strobe held low long enough for the synchroniser
    task automatic iack();
        @(posedge mclk_i);
        ack_n_o <= 1'b0;
        repeat (8) @(posedge mclk_i);
        ack_n_o <= 1'b1;
    endtask : iack
endmodule : uia_host
`default_nettype wire

// file: tb/testbench.sv
// testbench: directed and random checks of the interrupt arbiter against a bid model
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic                      mclk_i;
    logic                      rst_n_i;
    uia_pkg::uia_wb_req_s      wb_req;
    logic [31:0]               wb_dat;
    logic                      wb_ack;
    logic                      ack_n;
    logic                      irq_n;
    logic [7:0]                vec;
    logic [uia_pkg::BIDW-1:0]  cap;
    logic [8:0]                rxc;
    logic [8:0]                txc;
    logic                      rxe;
    logic [6:0]                ev;
    logic                      pb;
    logic [31:0]               q;
    int                        err_total;
    int                        checked;
    int                        cycles;
    int                        ty[7] = '{4, 14, 15, 6, 7, 8, 11};

    uia_arbiter dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat),
        .wb_ack_o(wb_ack), .intr_ack_strobe_n_i(ack_n), .intr_request_n_o(irq_n), .vector_o(vec),
        .current_winner_capture_o(cap), .rx_count_i(rxc), .rx_error_i(rxe), .tx_empty_i(txc),
        .wdog_evt_i(ev[0]), .brk_evt_i(ev[1]), .lpbk_evt_i(ev[2]), .cos_evt_i(ev[3]), .xon_evt_i(ev[4]),
        .ct_evt_i(ev[5]), .addr_evt_i(ev[6]), .cos_port_i(pb), .ct_unit_i(pb));
    uia_host host (.mclk_i(mclk_i), .wb_req_o(wb_req), .wb_dat_i(wb_dat), .wb_ack_i(wb_ack), .ack_n_o(ack_n));

    // 10 mhz clock
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    // hang guard
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : step
    task automatic pulse(input int j);
        @(posedge mclk_i);
        ev <= 7'(1 << j);
        @(posedge mclk_i);
        ev <= '0;
        step(8);
    endtask : pulse
    // highest eligible fifo bid, zero when none
    function automatic int best(int r, int t, int e, int lr, int lt, int th);
        int lim[4] = '{1, 128, 192, 256};
        int b = 0;
        int v;
        v = ((r > 255 ? 255 : r) << 4) | ((e != 0 ? 5 : 1) << 1);
        if (r >= lim[lr] && (v >> 1) > th) b = v;
        v = ((t > 255 ? 255 : t) << 4) | 4;
        if (t >= lim[lt] && (v >> 1) > th && v > b) b = v;
        return b;
    endfunction : best

    // main sequence
    initial begin
        int f, e, lr, lt, th, x;
        cycles = 0; err_total = 0; checked = 0;
        rst_n_i = 1'b0; rxc = '0; txc = '0; rxe = 1'b0; ev = '0; pb = 1'b0;
        void'($urandom(31));
        step(5);
        rst_n_i <= 1'b1;
        step(2);
        chk(32'h1, irq_n);
        chk(32'h0f, vec);
        chk(32'h0, cap);
        host.cyc(1'b0, uia_pkg::ADR_MASK, '0, q);
        chk(32'h0, q);
        host.cyc(1'b0, 8'h40, '0, q);
        chk(32'h0, q);
        host.wr(uia_pkg::ADR_VEC, 32'h3c);
        rxc <= 9'd10;
        step(8);
        chk(32'h1, irq_n);
        host.poll(q);
        chk(32'h0, q);
        host.wr(uia_pkg::ADR_MASK, 32'h1);
        step(8);
        chk(32'h0, irq_n);
        host.poll(q);
        chk(32'ha2, q);
        host.wr(uia_pkg::ADR_THR, 32'h51);
        step(8);
        chk(32'h1, irq_n);
        host.wr(uia_pkg::ADR_THR, 32'h50);
        step(8);
        chk(32'h0, irq_n);
        host.wr(uia_pkg::ADR_THR, 32'h0);
        // break event while masked, then status views and late winner
        host.wr(uia_pkg::ADR_PRG0, 32'h7f);
        pulse(1);
        host.cyc(1'b0, uia_pkg::ADR_STAT, '0, q);
        chk(32'h11, q);
        host.wr(uia_pkg::ADR_MODE1, 32'h40);
        host.cyc(1'b0, uia_pkg::ADR_STAT, '0, q);
        chk(32'h01, q);
        host.wr(uia_pkg::ADR_MODE1, 32'h0);
        host.wr(uia_pkg::ADR_MASK, 32'h11);
        host.iack();
        chk(32'hffc, cap);
        chk(32'h3c, vec);
        host.wr(uia_pkg::ADR_STAT, 32'h10);
        step(8);
        chk(32'hffc, cap);
        // modified vector: base bits 7:5 with type and channel of the rx bid
        host.wr(uia_pkg::ADR_VEC, 32'h13c);
        host.iack();
        chk(32'ha2, cap);
        chk(32'h22, vec);
        // each event source alone
        for (int j = 0; j < 7; j++) begin
            x = (j == 0) ? 2 : j + 3;
            f = $urandom % 128;
            pb <= 1'($urandom % 2);
            if (j > 0) host.wr(8'(uia_pkg::ADR_PRG0 + 4 * (j - 1)), f);
            host.wr(uia_pkg::ADR_MASK, 1 << x);
            pulse(j);
            host.poll(q);
            chk((j == 0) ? 32'ha8 : (f << 5) | (ty[j] << 1) | ((j == 3 || j == 5) ? pb : 1'b0), q);
            host.wr(uia_pkg::ADR_STAT, 1 << x);
        end
        // random fifo levels, start levels and thresholds
        host.wr(uia_pkg::ADR_MASK, 32'h00b);
        repeat (16) begin
            e = $urandom % 2;
            lr = e ? 0 : $urandom % 4;
            lt = $urandom % 4;
            th = $urandom % 1024;
            rxc <= 9'($urandom % 257);
            txc <= 9'($urandom % 257);
            rxe <= e[0];
            host.wr(uia_pkg::ADR_LVL, lr | (lt << 2));
            host.wr(uia_pkg::ADR_THR, th);
            step(8);
            f = best(rxc, txc, e, lr, lt, th);
            chk(f == 0, irq_n);
            if ($urandom % 2) host.iack();
            else host.poll(q);
            chk(f, cap);
        end
        conclude();
    end
endmodule : testbench
`default_nettype wire
